// >>> rtl/acd_pkg.sv
`default_nettype none
package acd_pkg;

  // command codes carried in the command field of the immediate control block
  localparam logic [7:0] OP_READ_DI     = 8'h00;  // current inbound line levels
  localparam logic [7:0] OP_READ_PI     = 8'h01;  // latched input, kept
  localparam logic [7:0] OP_READ_PI_RST = 8'h02;  // latched input, then cleared
  localparam logic [7:0] OP_ARM         = 8'h68;  // arm both dialers for interrupt
  localparam logic [7:0] OP_READ_STATUS = 8'h22;  // status word of addressed group
  localparam logic [7:0] OP_DEV_RESET   = 8'h6f;  // reset both dialers
  localparam logic [7:0] OP_WRITE_DO    = 8'h48;  // dial output control word

  // default device addresses of the two groups
  localparam logic [7:0] ADDR_IN_GROUP  = 8'h40;
  localparam logic [7:0] ADDR_OUT_GROUP = 8'h41;

  // condition codes
  localparam logic [2:0] CC_OK         = 3'h7;
  localparam logic [2:0] CC_BUSY       = 3'h1;
  localparam logic [2:0] CC_REJECT     = 3'h2;
  localparam logic [2:0] CC_DATA_CHECK = 3'h5;

  // interrupt information byte while an interrupt is pending (code 11 in bits 6-7)
  localparam logic [7:0] IIB_PENDING = 8'h03;

  // word bit n (bit 0 is the most significant) sits at vector index 15-n
  localparam int unsigned STS_ARMED_IDX = 13;  // bit 2 of both status words
  localparam int unsigned STS_SYNC_IDX  = 12;  // bit 3
  localparam int unsigned STS_TEST1_IDX = 11;  // bit 4 (diag sync in output word)
  localparam int unsigned STS_TEST0_IDX = 10;  // bit 5
  localparam int unsigned STS_INT_LO    = 8;   // bits 6-7
  localparam int unsigned WR_CRQ_IDX    = 13;  // bit 2, port one; bit 10 is idx 5
  localparam int unsigned WR_DPR_IDX    = 12;  // bit 3, port one; bit 11 is idx 4
  localparam int unsigned WR_DIG_LO     = 8;   // bits 4-7, port one; bits 12-15 at idx 0
  localparam int unsigned PORT_STRIDE   = 8;   // port two sits one byte lower
  localparam int unsigned EV_LO         = 8;   // latched bits 3-7 at idx 12:8

  // command as presented by the channel
  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  dev_addr;
    logic [15:0] data;
  } acd_cmd_t;

  // answer returned to the channel
  typedef struct packed {
    logic [15:0] data;
    logic [2:0]  cc;
  } acd_resp_t;

  // inbound lines of one dialer
  typedef struct packed {
    logic next_digit_request;
    logic abandon_and_retry;
    logic power_indication;
    logic line_occupied;
    logic far_station_connected;
  } acd_lines_t;

  // outbound lines of one dialer
  typedef struct packed {
    logic       call_request_line;
    logic       digit_present_line;
    logic [3:0] digit_signal_lines;
  } acd_dial_t;

  // interrupt state code, as shown in status bits 6-7
  typedef enum logic [1:0] {
    IS_NONE     = 2'b00,
    IS_SERVICED = 2'b01,
    IS_PENDING  = 2'b11
  } acd_istate_t;

endpackage
`default_nettype wire

// >>> rtl/acd_edge_det.sv
`default_nettype none
module acd_edge_det #(
  parameter int unsigned W         = 5,
  parameter logic [4:0]  FALL_MASK = 5'h06  // lines that signal on turning off
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // lines and events
  input  wire logic [W-1:0] lines,
  output logic      [W-1:0] events
);

  logic [W-1:0] prev_ff;   // line levels one cycle back
  logic         primed_ff; // no events until a first sample exists

  ////////////////////////////////////////////////////////////////////////////
  // sample lines; priming avoids a false edge from the reset value
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prev_ff   <= '0;
      primed_ff <= 1'b0;
    end else if (ce) begin
      prev_ff   <= lines;
      primed_ff <= 1'b1;
    end
  end

  // rising or falling edge per line, chosen by the mask
  always_comb begin
    for (int i = 0; i < W; i++) begin
      events[i] = primed_ff & (FALL_MASK[i] ? (prev_ff[i] & ~lines[i])
                                            : (~prev_ff[i] & lines[i]));
    end
  end

endmodule // acd_edge_det
`default_nettype wire

// >>> rtl/acd_intr_state.sv
`default_nettype none
module acd_intr_state (
  // clock and reset
  input  wire logic           core_clk,
  input  wire logic           rst_n,
  input  wire logic           ce,
  // control
  input  wire logic           clear,    // device reset
  input  wire logic           raise,    // new interrupt cause
  input  wire logic           ack,      // channel accepted the interrupt
  input  wire logic           release_i,// cause gone (register empty / ready)
  // state code
  output acd_pkg::acd_istate_t state
);

  acd_pkg::acd_istate_t state_ff;
  acd_pkg::acd_istate_t nxt_state;

  // next state; a fresh cause beats the release in the serviced state
  always_comb begin
    nxt_state = state_ff;
    if (clear) begin
      nxt_state = acd_pkg::IS_NONE;
    end else begin
      unique case (state_ff)
        acd_pkg::IS_NONE: begin
          if (raise) nxt_state = acd_pkg::IS_PENDING;
        end
        acd_pkg::IS_PENDING: begin
          if (ack && !raise) nxt_state = acd_pkg::IS_SERVICED;
        end
        acd_pkg::IS_SERVICED: begin
          if (raise) nxt_state = acd_pkg::IS_PENDING;
          else if (release_i) nxt_state = acd_pkg::IS_NONE;
        end
        default: nxt_state = acd_pkg::IS_NONE;  // code 10 is never held
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (!rst_n) state_ff <= acd_pkg::IS_NONE;
    else if (ce) state_ff <= nxt_state;
  end

  assign state = state_ff;

endmodule // acd_intr_state
`default_nettype wire

// >>> rtl/acd_dialer_port.sv
`default_nettype none
// Functional notes
// RULE_01: status read returns group status word
// RULE_02: input and output groups have separate formats
// RULE_03: input bit 2 armed, bit 3 sync
// RULE_04: input bits 4,5 report test modes
// RULE_05: code 11 pending, also in info byte
// RULE_06: code 01 serviced but latched uncleared; never 10
// RULE_07: output bits 2,3,4 modes; rest unused
// RULE_08: output code 01 serviced, ready inactive
// RULE_09: device reset clears interrupt, modes, data
// RULE_10: device reset hits both dialers together
// RULE_11: write bit 2/10 drives call request
// RULE_12: write bit 3/11 drives digit present
// RULE_13: write bits 4-7/12-15 give BCD digit
// RULE_14: write refused busy while interrupt pending
// RULE_15: data check means command not executed
// RULE_16: arm both dialers; busy if pending
// RULE_17: interrupt on listed line transitions
// RULE_18: dial outputs hold until write or reset
module acd_dialer_port #(
  parameter logic [7:0] IN_ADDR  = acd_pkg::ADDR_IN_GROUP,
  parameter logic [7:0] OUT_ADDR = acd_pkg::ADDR_OUT_GROUP
) (
  // clock, reset, enable
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  // channel command and answer
  input  wire logic                    cmd_valid,
  input  wire acd_pkg::acd_cmd_t       cmd,
  input  wire logic                    cmd_data_check,
  output logic                         resp_valid,
  output acd_pkg::acd_resp_t           resp,
  // channel interrupt
  output logic                         intr_req,
  output logic [7:0]                   interrupt_info_byte,
  input  wire logic                    intr_ack,
  // calling unit, index 0 is dialer port one
  input  wire acd_pkg::acd_lines_t [1:0] dialer_lines,
  input  wire logic                    out_ready,
  output acd_pkg::acd_dial_t           dialer_port_one,
  output acd_pkg::acd_dial_t           dialer_port_two
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic                 armed_ff;      // latched-input interrupt mode
  logic [15:0]          latched_ff;    // latched-input register
  acd_pkg::acd_dial_t   dial_one_ff;   // port one outbound lines
  acd_pkg::acd_dial_t   dial_two_ff;   // port two outbound lines
  acd_pkg::acd_resp_t   resp_ff;       // answer data and code
  acd_pkg::acd_resp_t   nxt_resp;
  logic                 resp_valid_ff;
  logic                 hit_in;        // command addresses the input group
  logic                 hit_out;       // command addresses the output group
  logic                 exec;          // addressed, no data check
  logic                 busy;          // an interrupt is pending
  logic                 do_arm;
  logic                 do_rst;
  logic                 do_write;
  logic                 do_pi_clear;
  logic [4:0]           ev_one;        // line events of port one
  logic [4:0]           ev_two;        // line events of port two
  logic [15:0]          ev_bits;       // events placed at latched positions
  logic                 raise_in;
  logic                 release_in;
  acd_pkg::acd_istate_t in_state;
  acd_pkg::acd_istate_t out_state;
  logic [15:0]          in_status;
  logic [15:0]          out_status;
  logic [15:0]          di_word;

  // place a dialer's five line bits at a port's byte of the word
  function automatic logic [15:0] place5(input logic [4:0] one, input logic [4:0] two);
    logic [15:0] w;
    w = '0;
    w[acd_pkg::EV_LO +: 5] = one;
    w[acd_pkg::EV_LO - acd_pkg::PORT_STRIDE +: 5] = two;
    return w;
  endfunction

  // pick one dialer's outbound lines out of a write word
  // sh: zero for port one, a byte for port two
  function automatic acd_pkg::acd_dial_t dial_of(input logic [15:0] d, input int unsigned sh);
    acd_pkg::acd_dial_t r;
    r.call_request_line  = d[acd_pkg::WR_CRQ_IDX - sh];
    r.digit_present_line = d[acd_pkg::WR_DPR_IDX - sh];
    r.digit_signal_lines = d[acd_pkg::WR_DIG_LO - sh +: 4];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode
  // a data check blocks all effects but still answers
  assign hit_in   = cmd.dev_addr == IN_ADDR;
  assign hit_out  = cmd.dev_addr == OUT_ADDR;
  assign exec     = ce & cmd_valid & (hit_in | hit_out) & ~cmd_data_check;  // [RULE_15]
  assign busy     = (in_state == acd_pkg::IS_PENDING) | (out_state == acd_pkg::IS_PENDING);
  assign do_arm   = exec & (cmd.opcode == acd_pkg::OP_ARM) & ~busy;  // [RULE_16]
  // either address resets both dialers: they share the groups
  assign do_rst   = exec & (cmd.opcode == acd_pkg::OP_DEV_RESET);  // [RULE_10]
  assign do_write = exec & hit_out & (cmd.opcode == acd_pkg::OP_WRITE_DO) & ~busy;  // [RULE_14]
  assign do_pi_clear = exec & hit_in & (cmd.opcode == acd_pkg::OP_READ_PI_RST);

  ////////////////////////////////////////////////////////////////////////////
  // line events: next digit, retry, connected on rising; power, line on falling
  // limitation: pulses shorter than a cycle are missed
  acd_edge_det #(.W(5), .FALL_MASK(5'h06)) u_edge_one (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .lines    (dialer_lines[0]),
    .events   (ev_one)
  );

  acd_edge_det #(.W(5), .FALL_MASK(5'h06)) u_edge_two (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .lines    (dialer_lines[1]),
    .events   (ev_two)
  );

  assign ev_bits = place5(ev_one, ev_two);

  ////////////////////////////////////////////////////////////////////////////
  // arm mode; cleared only by device reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      armed_ff <= 1'b0;
    end else if (ce) begin
      if (do_rst) armed_ff <= 1'b0;  // [RULE_09]
      else if (do_arm) armed_ff <= 1'b1;  // [RULE_16]
    end
  end

  // latched-input register; an event in the clearing cycle survives
  // a clear beating an event would drop a line change
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      latched_ff <= '0;
    end else if (ce) begin
      if (do_rst) latched_ff <= '0;  // [RULE_09]
      else latched_ff <= (do_pi_clear ? 16'h0000 : latched_ff) | (armed_ff ? ev_bits : 16'h0000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt state of the input group
  assign raise_in   = armed_ff & (|ev_bits);  // [RULE_17]
  assign release_in = ~(|latched_ff) | do_pi_clear;  // [RULE_06]

  acd_intr_state u_int_in (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .clear     (do_rst),
    .raise     (raise_in),
    .ack       (intr_ack),
    .release_i (release_in),
    .state     (in_state)
  );

  // output group: nothing in dialer use raises it, so it only reports,
  // leaving its serviced state once ready returns
  acd_intr_state u_int_out (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .clear     (do_rst),
    .raise     (1'b0),
    .ack       (intr_ack),
    .release_i (out_ready),  // [RULE_08]
    .state     (out_state)
  );

  // interrupt presented to the channel with code 11 in the info byte
  // limitation: one ack services both groups
  assign intr_req            = busy;  // [RULE_05]
  assign interrupt_info_byte = busy ? acd_pkg::IIB_PENDING : 8'h00;  // [RULE_05]

  ////////////////////////////////////////////////////////////////////////////
  // status words; sync and test modes have no use here and read zero
  // trade-off: commandless modes are tied, not stored
  always_comb begin
    in_status = '0;
    in_status[acd_pkg::STS_ARMED_IDX] = armed_ff;  // [RULE_03]
    in_status[acd_pkg::STS_SYNC_IDX]  = 1'b0;  // [RULE_03]
    in_status[acd_pkg::STS_TEST1_IDX] = 1'b0;  // [RULE_04]
    in_status[acd_pkg::STS_TEST0_IDX] = 1'b0;  // [RULE_04]
    in_status[acd_pkg::STS_INT_LO +: 2] = in_state;  // [RULE_05] [RULE_06]
    out_status = '0;  // [RULE_07]
    out_status[acd_pkg::STS_ARMED_IDX] = 1'b0;  // disable mode never set
    out_status[acd_pkg::STS_INT_LO +: 2] = out_state;  // [RULE_08]
  end

  // inbound levels, power and line reported as 'off'
  assign di_word = place5({dialer_lines[0].next_digit_request,
                           dialer_lines[0].abandon_and_retry,
                           ~dialer_lines[0].power_indication,
                           ~dialer_lines[0].line_occupied,
                           dialer_lines[0].far_station_connected},
                          {dialer_lines[1].next_digit_request,
                           dialer_lines[1].abandon_and_retry,
                           ~dialer_lines[1].power_indication,
                           ~dialer_lines[1].line_occupied,
                           dialer_lines[1].far_station_connected});

  ////////////////////////////////////////////////////////////////////////////
  // answer for the command now presented
  always_comb begin
    nxt_resp.data = '0;
    nxt_resp.cc   = acd_pkg::CC_OK;
    if (cmd_data_check) begin
      nxt_resp.cc = acd_pkg::CC_DATA_CHECK;  // [RULE_15]
    end else begin
      unique case (cmd.opcode)
        acd_pkg::OP_READ_STATUS: begin
          nxt_resp.data = hit_out ? out_status : in_status;  // [RULE_01] [RULE_02]
        end
        acd_pkg::OP_READ_DI: begin
          if (hit_in) nxt_resp.data = di_word;
          else nxt_resp.cc = acd_pkg::CC_REJECT;
        end
        acd_pkg::OP_READ_PI, acd_pkg::OP_READ_PI_RST: begin
          if (hit_in) nxt_resp.data = latched_ff;
          else nxt_resp.cc = acd_pkg::CC_REJECT;
        end
        acd_pkg::OP_ARM: begin
          if (busy) nxt_resp.cc = acd_pkg::CC_BUSY;  // [RULE_16]
        end
        acd_pkg::OP_DEV_RESET: begin
          nxt_resp.cc = acd_pkg::CC_OK;
        end
        acd_pkg::OP_WRITE_DO: begin
          if (!hit_out) nxt_resp.cc = acd_pkg::CC_REJECT;
          else if (busy) nxt_resp.cc = acd_pkg::CC_BUSY;  // [RULE_14]
        end
        default: nxt_resp.cc = acd_pkg::CC_REJECT;  // unsupported command
      endcase
    end
  end

  // register the answer; unaddressed commands get none
  // resp holds so a slow reader still finds it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      resp_valid_ff <= 1'b0;
      resp_ff       <= '0;
    end else if (ce) begin
      resp_valid_ff <= cmd_valid & (hit_in | hit_out);
      if (cmd_valid & (hit_in | hit_out)) resp_ff <= nxt_resp;
    end
  end

  assign resp_valid = resp_valid_ff;
  assign resp       = resp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // outbound dial lines; held between writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dial_one_ff <= '0;
      dial_two_ff <= '0;
    end else if (ce) begin
      if (do_rst) begin
        dial_one_ff <= '0;  // [RULE_09] [RULE_10]
        dial_two_ff <= '0;
      end else if (do_write) begin
        // one word sets both dialers at once [RULE_11] [RULE_12] [RULE_13]
        dial_one_ff <= dial_of(cmd.data, 0);
        dial_two_ff <= dial_of(cmd.data, acd_pkg::PORT_STRIDE);
      end
    end
  end  // otherwise held [RULE_18]

  assign dialer_port_one = dial_one_ff;
  assign dialer_port_two = dial_two_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // all checks on core_clk, off while rst_n is low
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_status_read: assert property (exec && cmd.opcode == acd_pkg::OP_READ_STATUS  // [RULE_01]
    |=> resp_valid && resp.data == $past(hit_out ? out_status : in_status))
    else $error("status word answer wrong");

  a_never_ten: assert property (in_state != 2'b10 && out_state != 2'b10)  // [RULE_06]
    else $error("interrupt code 10 seen");

  a_iib_pending: assert property (intr_req |-> interrupt_info_byte == 8'h03  // [RULE_05]
    && (in_status[9:8] == 2'b11 || out_status[9:8] == 2'b11))
    else $error("info byte not 11 while pending");

  a_write_busy: assert property (exec && hit_out && busy  // [RULE_14]
    && cmd.opcode == acd_pkg::OP_WRITE_DO
    |=> resp.cc == 3'h1 && $stable(dialer_port_one) && $stable(dialer_port_two))
    else $error("write executed while busy");

  a_write_lines: assert property (do_write |=> dialer_port_one.call_request_line  // [RULE_11]
    == $past(cmd.data[13]) && dialer_port_two.digit_present_line == $past(cmd.data[4])
    && dialer_port_one.digit_signal_lines == $past(cmd.data[11:8]))
    else $error("dial lines differ from write word");

  a_data_check: assert property (ce && cmd_valid && cmd_data_check  // [RULE_15]
    && (hit_in || hit_out)
    |=> resp.cc == 3'h5 && $stable(dialer_port_one) && $stable(armed_ff))
    else $error("command ran despite data check");

  a_reset_both: assert property (do_rst |=> !armed_ff && dialer_port_one == '0  // [RULE_10]
    && dialer_port_two == '0 && latched_ff == '0 && !intr_req)
    else $error("device reset left state behind");

  a_arm_busy: assert property (exec && cmd.opcode == acd_pkg::OP_ARM && busy  // [RULE_16]
    |=> $stable(armed_ff) && resp.cc == 3'h1)
    else $error("arm taken while pending");

  a_event_raise: assert property (ce && armed_ff && |ev_bits && !do_rst  // [RULE_17]
    && in_state == acd_pkg::IS_NONE |=> in_state == acd_pkg::IS_PENDING ##0 intr_req)
    else $error("line event raised no interrupt");

  a_dial_hold: assert property (!do_write && !do_rst  // [RULE_18]
    |=> $stable(dialer_port_one) && $stable(dialer_port_two))
    else $error("dial lines moved without write");

  a_ack_service: assert property (ce && intr_ack && !raise_in && !do_rst  // [RULE_06]
    && in_state == acd_pkg::IS_PENDING |=> in_state == acd_pkg::IS_SERVICED)
    else $error("ack left interrupt pending");

  a_serviced_hold: assert property (in_state == acd_pkg::IS_SERVICED && |latched_ff  // [RULE_06]
    && !do_pi_clear && !do_rst |=> in_state != acd_pkg::IS_NONE)
    else $error("serviced code dropped early");

  a_status_format: assert property (out_status[15:10] == 6'h00  // [RULE_07]
    && out_status[7:0] == 8'h00 && in_status[15:14] == 2'b00 && in_status[7:0] == 8'h00)
    else $error("unused status bits set");

endmodule // acd_dialer_port
`default_nettype wire

// >>> sim/acd_acu_model.sv
`default_nettype none
// behavioural calling unit on the far side of both dialer ports
module acd_acu_model (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  // dial lines from the block
  input  wire acd_pkg::acd_dial_t       port_one,
  input  wire acd_pkg::acd_dial_t       port_two,
  // bench control: power loss per port
  input  wire logic [1:0]               drop_power,
  // inbound lines to the block
  output var  acd_pkg::acd_lines_t [1:0] lines,
  output var  logic                     out_ready
);
  acd_pkg::acd_dial_t dial [2];  // both ports side by side

  assign dial[0] = port_one;
  assign dial[1] = port_two;

  ////////////////////////////////////////////////////////////////////////////////
  // line levels: power and line occupied idle high, the rest idle low
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (!rst_n) begin
        lines[i] <= 5'h06;
      end else begin
        // asks for the next digit while a call is requested and no digit shown
        lines[i].next_digit_request    <= dial[i].call_request_line &
                                          ~dial[i].digit_present_line;
        lines[i].abandon_and_retry     <= 1'b0;
        lines[i].power_indication      <= ~drop_power[i];  // off edge raises
        lines[i].line_occupied         <= 1'b1;
        lines[i].far_station_connected <= 1'b0;
      end
    end
  end

  // output group ready is always active, so serviced state never lingers
  assign out_ready = 1'b1;
endmodule  // acd_acu_model
`default_nettype wire

// >>> sim/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus, driven at the falling edge
  logic               core_clk       = 1'b0;
  logic               rst_n          = 1'b0;
  logic               cmd_valid      = 1'b0;
  logic               cmd_data_check = 1'b0;
  logic               intr_ack       = 1'b0;
  logic [1:0]         drop_power     = 2'h0;
  acd_pkg::acd_cmd_t  cmd            = '0;
  // observed
  logic                      resp_valid;
  logic                      intr_req;
  logic                      out_ready;
  logic [7:0]                info;
  acd_pkg::acd_resp_t        resp;
  acd_pkg::acd_resp_t        r;
  acd_pkg::acd_lines_t [1:0] lines;
  acd_pkg::acd_dial_t        d1;
  acd_pkg::acd_dial_t        d2;
  int                        err_total = 0;
  int                        checked   = 0;

  always #4 core_clk = ~core_clk;

  acd_dialer_port acd_dialer_port_inst (
    .core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_data_check(cmd_data_check), .resp_valid(resp_valid), .resp(resp),
    .intr_req(intr_req), .interrupt_info_byte(info), .intr_ack(intr_ack),
    .dialer_lines(lines), .out_ready(out_ready), .dialer_port_one(d1), .dialer_port_two(d2));

  acd_acu_model acd_acu_model_inst (
    .core_clk(core_clk), .rst_n(rst_n), .port_one(d1), .port_two(d2),
    .drop_power(drop_power), .lines(lines), .out_ready(out_ready));

  ////////////////////////////////////////////////////////////////////////////////
  // compare one value, count it, report a mismatch at once
  task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one channel command: one-cycle valid, bounded wait for the answer, check cc
  task automatic op(input logic [7:0] code, input logic [7:0] addr, input logic [15:0] data,
                    input logic dchk, input logic [2:0] ecc);
    int n;
    @(negedge core_clk);
    cmd_valid      = 1'b1;
    cmd            = '{code, addr, data};
    cmd_data_check = dchk;
    @(negedge core_clk);
    cmd_valid      = 1'b0;
    cmd            = ~cmd;  // idle bus never shows the last command
    cmd_data_check = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 4) begin
      @(negedge core_clk);
      n++;
    end
    chk("resp_valid", 19'h1, {18'h0, resp_valid});
    r = resp;
    chk("cc", {16'h0, ecc}, {16'h0, r.cc});
  endtask

  // status read of one group, compare the word
  task automatic sts(input logic [7:0] addr, input logic [15:0] exp);
    op(acd_pkg::OP_READ_STATUS, addr, 16'h0, 1'b0, acd_pkg::CC_OK);
    chk("status", {3'h0, exp}, {3'h0, r.data});
  endtask

  // both dial ports at once
  task automatic dial(input logic [5:0] e1, input logic [5:0] e2);
    chk("dial", {7'h0, e1, e2}, {7'h0, d1, d2});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    dial(6'h00, 6'h00);
    chk("info", 19'h0, {11'h0, info});
    sts(acd_pkg::ADDR_IN_GROUP, 16'h0000);
    sts(acd_pkg::ADDR_OUT_GROUP, 16'h0000);
    $display("t_reset done");
  endtask

  task automatic t_write;
    op(acd_pkg::OP_WRITE_DO, acd_pkg::ADDR_OUT_GROUP, 16'h2917, 1'b0,
       acd_pkg::CC_OK);
    dial(6'h29, 6'h17);
    repeat (5) @(negedge core_clk);
    dial(6'h29, 6'h17);
    op(acd_pkg::OP_WRITE_DO, acd_pkg::ADDR_OUT_GROUP, 16'h1010, 1'b0,
       acd_pkg::CC_OK);
    dial(6'h10, 6'h10);
    $display("t_write done");
  endtask

  task automatic t_refuse;
    op(acd_pkg::OP_WRITE_DO, acd_pkg::ADDR_OUT_GROUP, 16'h3f3f, 1'b1, acd_pkg::CC_DATA_CHECK);
    dial(6'h10, 6'h10);
    op(acd_pkg::OP_WRITE_DO, acd_pkg::ADDR_IN_GROUP, 16'h3f3f, 1'b0,
       acd_pkg::CC_REJECT);
    dial(6'h10, 6'h10);
    op(acd_pkg::OP_ARM, acd_pkg::ADDR_IN_GROUP, 16'h0, 1'b1, acd_pkg::CC_DATA_CHECK);
    sts(acd_pkg::ADDR_IN_GROUP, 16'h0000);
    $display("t_refuse done");
  endtask

  // arm, power loss on port two, busy refusals, service and clear
  task automatic t_intr;
    int n;
    op(acd_pkg::OP_ARM, acd_pkg::ADDR_IN_GROUP, 16'h0, 1'b0, acd_pkg::CC_OK);
    sts(acd_pkg::ADDR_IN_GROUP, 16'h2000);
    drop_power = 2'b10;
    n = 0;
    while (intr_req !== 1'b1 && n < 8) begin
      @(negedge core_clk);
      n++;
    end
    chk("intr_req", 19'h1, {18'h0, intr_req});
    chk("info", 19'h03, {11'h0, info});
    sts(acd_pkg::ADDR_IN_GROUP, 16'h2300);
    op(acd_pkg::OP_WRITE_DO, acd_pkg::ADDR_OUT_GROUP, 16'h2f2f, 1'b0,
       acd_pkg::CC_BUSY);
    dial(6'h10, 6'h10);
    op(acd_pkg::OP_ARM, acd_pkg::ADDR_IN_GROUP, 16'h0, 1'b0, acd_pkg::CC_BUSY);
    intr_ack = 1'b1;
    @(negedge core_clk);
    intr_ack = 1'b0;
    @(negedge core_clk);
    chk("intr_req", 19'h0, {18'h0, intr_req});
    sts(acd_pkg::ADDR_IN_GROUP, 16'h2100);
    sts(acd_pkg::ADDR_OUT_GROUP, 16'h0000);
    op(acd_pkg::OP_READ_PI, acd_pkg::ADDR_IN_GROUP, 16'h0, 1'b0, acd_pkg::CC_OK);
    chk("latched", 19'h0004, {3'h0, r.data});
    op(acd_pkg::OP_READ_DI, acd_pkg::ADDR_IN_GROUP, 16'h0, 1'b0, acd_pkg::CC_OK);
    chk("lines", 19'h0004, {3'h0, r.data});
    op(acd_pkg::OP_READ_PI_RST, acd_pkg::ADDR_IN_GROUP, 16'h0, 1'b0, acd_pkg::CC_OK);
    chk("latched", 19'h0004, {3'h0, r.data});
    sts(acd_pkg::ADDR_IN_GROUP, 16'h2000);
    $display("t_intr done");
  endtask

  // reset aimed at the output group clears both ports and the arm
  task automatic t_dev_reset;
    drop_power = 2'b00;
    op(acd_pkg::OP_WRITE_DO, acd_pkg::ADDR_OUT_GROUP, 16'h1919, 1'b0,
       acd_pkg::CC_OK);
    op(acd_pkg::OP_DEV_RESET, acd_pkg::ADDR_OUT_GROUP, 16'h0, 1'b0, acd_pkg::CC_OK);
    dial(6'h00, 6'h00);
    sts(acd_pkg::ADDR_IN_GROUP, 16'h0000);
    $display("t_dev_reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // whole run is under a hundred cycles; the limit allows 4000
  initial begin
    #(8 * 4000);
    err_total++;
    summarize();
  end

  initial begin
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    t_reset();
    t_write();
    t_refuse();
    t_intr();
    t_dev_reset();
    summarize();
  end
endmodule  // tb_top
`default_nettype wire
